// *** verilog/ebi_params.svh ***
// Constants of the external bus interface: cycle framing, modes, sizes.
// Assumes inclusion by the package and the design files by bare name.
`ifndef EBI_PARAMS_SVH
`define EBI_PARAMS_SVH

// ==========================================================================
// Cycle framing
// ==========================================================================
`define EBI_STATES_PER_CYCLE   5
`define EBI_STATE_W            3
`define EBI_ALE_STATE          3'h0
`define EBI_ADDR_STATE         3'h1
`define EBI_STROBE_STATE       3'h2
`define EBI_SAMPLE_STATE       3'h3
`define EBI_LAST_STATE         3'h4

// ==========================================================================
// Program modes and sizes
// ==========================================================================
`define EBI_MODE_INTERNAL      2'h0
`define EBI_MODE_MIXED         2'h1
`define EBI_MODE_EXTERNAL      2'h2
`define EBI_ROM_TOP            12'h07FF
`define EBI_RESET_PC           12'h0000
`define EBI_EXP_OP_WRITE       2'h1
`define EBI_EXP_OP_READ        2'h0
`define EBI_EXP_PORT_BASE      3'h4
`define EBI_RAM_DEPTH          128

`endif

// *** verilog/ebi_pkg.sv ***
// Types shared by the external bus interface files.
// Assumes ebi_params.svh is reachable on the include path.
package ebi_pkg;
`include "ebi_params.svh"

    // ======================================================================
    // Request kinds from the core
    // ======================================================================
    typedef enum logic [2:0] {
        EBI_OP_NONE,
        EBI_OP_FETCH,
        EBI_OP_DREAD,
        EBI_OP_DWRITE,
        EBI_OP_EXP_RD,
        EBI_OP_EXP_WR
    } ebi_op_t;

    // Core request bundle
    typedef struct packed {
        ebi_op_t     op;      // Kind of access
        logic [11:0] addr;    // Program counter or pointer value
        logic [7:0]  wdata;   // Store data or expander nibble
        logic [1:0]  port;    // Expander port 0..3 (numbers 4..7)
    } ebi_req_t;

    // Pin outputs as one bundle
    typedef struct packed {
        logic [7:0] bus_o;    // Data bus lines out
        logic       bus_oe;   // Data bus drive enable
        logic [3:0] p2_o;     // Expander nibble lines out
        logic       p2_oe;    // Expander nibble lines drive enable
        logic       ale;      // Address latch strobe
        logic       fetch_n;  // Program fetch strobe, active low
        logic       rd_n;     // Read strobe, active low
        logic       wr_n;     // Store strobe, active low
        logic       exp_stb;  // Expander strobe
    } ebi_pins_t;
endpackage

// *** verilog/ebi_sync3.sv ***
// Three-stage synchroniser for one pin input.
// Assumes a single clock; output changes once stages two and three agree.
`timescale 1ns/1ps
module ebi_sync3 (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic pin_in,
    output logic      level_out
);
    // ======================================================================
    // Stages
    // ======================================================================
    logic [2:0] stage_q;    // Sync chain, bit 0 is metastable
    logic       level_q;    // Filtered level

    // Shift chain; first stage only feeds the second
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            stage_q <= 3'h0;
            level_q <= 1'b0;
        end else begin
            stage_q <= {stage_q[1:0], pin_in};
            if (stage_q[1] == stage_q[2]) begin
                level_q <= stage_q[2];
            end
        end
    end

    assign level_out = level_q;
endmodule

// *** verilog/ebi_core.sv ***
// External bus interface: cycle framing, fetch, data access, expander link,
// program read-out, single step and RAM guard in standby.
// Assumes one 10 MHz clock; pins split into in/out/enable at the boundary.
// Operation
// - Five states per cycle, one cycle per request
// - Clock output only after enable instruction
// - One address latch pulse per cycle
// - Internal, mixed, external program modes
// - Twelve-bit address on bus plus nibble
// - Fetch strobe active during external fetch
// - Bus turns input, fetched byte taken
// - Pointer value out, then eight data bits
// - Read or store strobe, never both
// - Store data valid while strobe low; read sampled
// - Expander uses nibble lines and strobe pulse
// - Expander ports numbered four to seven
// - Two nibbles: opcode/port, then data
// - Read-out address latched on reset rise
// - Single step low stops after one more cycle, high runs freely
// - Reset low blocks all RAM access
// - Bus floats when idle
`timescale 1ns/1ps
module ebi_core #(
    parameter int ROM_TOP = 2047    // Last internal program address
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    // Core side
    input  wire ebi_pkg::ebi_req_t req_in,          // Request for next cycle
    input  wire logic [1:0]       expander_strobe_mode_in,     // Program mode select
    input  wire logic             clk_out_en_in,    // Enable instruction done
    input  wire logic             phase2_in,        // Internal second-phase clock
    output logic                  req_ready_out,    // Request taken this edge
    output logic                  rdata_valid_out,  // Read data valid pulse
    output logic [7:0]            rdata_out,        // Fetched or read byte
    output logic                  ext_fetch_out,    // Current fetch goes outside
    output logic                  stopped_out,      // Held by single step
    // RAM guard
    input  wire logic             ram_we_in,        // Core RAM write wish
    input  wire logic             ram_re_in,        // Core RAM read wish
    output logic                  ram_we_out,       // Gated RAM write
    output logic                  ram_re_out,       // Gated RAM read
    // Pins
    input  wire logic [7:0]       bus_in,           // Data bus lines in
    output logic [7:0]            bus_out,          // Data bus lines out
    output logic                  bus_oe_out,       // Data bus drive enable
    input  wire logic [3:0]       p2_in,            // Expander nibble lines in
    output logic [3:0]            p2_out,           // Expander nibble lines out
    output logic                  p2_oe_out,        // Nibble lines drive enable
    output logic                  ale_out,          // Address latch strobe
    output logic                  fetch_n_out,      // Program fetch strobe
    output logic                  rd_n_out,         // Read strobe
    output logic                  wr_n_out,         // Store strobe
    output logic                  exp_stb_out,      // Expander strobe
    output logic                  clk_pin_out,      // Clock output pin
    input  wire logic             ext_sel_hi_in,    // Access select at high level
    input  wire logic             reset_pin_in,     // Reset pin, high = run
    input  wire logic             step_in,          // Single step pin
    input  wire logic [7:0]       rom_data_in,      // Internal program byte
    output logic [10:0]           rom_addr_out      // Internal program address
);
    import ebi_pkg::*;
`include "ebi_params.svh"

    // ======================================================================
    // State
    // ======================================================================
    typedef enum {
        EBI_ST_RUN,
        EBI_ST_STOP,
        EBI_ST_READOUT
    } ebi_mode_t;

    typedef struct packed {
        logic [2:0]  phase;     // State within machine cycle
        ebi_op_t     op;        // Access in progress
        logic [11:0] addr;      // Latched address
        logic [7:0]  wdata;     // Latched store data
        logic [1:0]  port;      // Expander port
        logic [1:0]  nib;       // Expander nibble step
        logic [7:0]  rdata;     // Captured read data
        logic        rvalid;    // Read data pulse
        logic        clk_en;    // Clock output enabled
        logic        run_mode;  // Unused; reset to zero, never changed
        logic        ro_mode;   // Program read-out active
        logic        rst_pin;   // Previous reset pin level
        logic        step_seen; // Cycle taken while step low
        logic [10:0] ro_addr;   // Read-out address
        ebi_pins_t   pins;      // Registered pin outputs
    } ebi_state_t;

    ebi_state_t s_q;    // Registered state
    ebi_state_t s_d;    // Next state
    logic       rst_s;  // Synced reset pin
    logic       step_s; // Synced single step
    logic       sel_s;  // Synced read-out select
    logic       ext_f;  // Fetch target is outside
    logic       start;  // Cycle boundary

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    ebi_sync3 u_sync_rst (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .pin_in    (reset_pin_in),
        .level_out (rst_s)
    );
    ebi_sync3 u_sync_step (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .pin_in    (step_in),
        .level_out (step_s)
    );
    ebi_sync3 u_sync_sel (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .pin_in    (ext_sel_hi_in),
        .level_out (sel_s)
    );

    // Mode decision for the fetch address
    always_comb begin
        case (expander_strobe_mode_in)
            `EBI_MODE_EXTERNAL: ext_f = 1'b1;
            `EBI_MODE_MIXED:    ext_f = (req_in.addr > 12'(ROM_TOP));
            default:            ext_f = 1'b0;
        endcase
    end

    // New cycle starts when the last state ends
    assign start = (s_q.phase == `EBI_LAST_STATE);

    // ======================================================================
    // Next-state logic
    // ======================================================================
    always_comb begin
        s_d         = s_q;
        s_d.rvalid  = 1'b0;
        s_d.rst_pin = rst_s;
        s_d.clk_en  = s_q.clk_en | clk_out_en_in;
        // Five states per machine cycle; one request taken per cycle
        s_d.phase   = start ? `EBI_ALE_STATE : s_q.phase + 3'h1;

        // Read-out entry while reset is low; address latch on reset rise
        if (sel_s && !rst_s) begin
            s_d.ro_mode      = 1'b1;
            s_d.pins.bus_oe  = 1'b0;
        end
        if (s_q.ro_mode && rst_s && !s_q.rst_pin) begin
            s_d.ro_addr = {1'b0, p2_in[1:0], bus_in};
        end
        if (!sel_s) begin
            s_d.ro_mode = 1'b0;
        end

        if (s_q.ro_mode) begin
            // Drive addressed byte while reset stays high
            s_d.pins.bus_o  = rom_data_in;
            s_d.pins.bus_oe = rst_s;
            s_d.phase       = `EBI_ALE_STATE;
        end else if (!rst_s) begin
            // Held in reset: float bus, no strobes
            s_d.op          = EBI_OP_NONE;
            s_d.phase       = `EBI_ALE_STATE;
            s_d.pins        = '{bus_o: 8'h00, bus_oe: 1'b0, p2_o: 4'h0, p2_oe: 1'b0,
                                ale: 1'b0, fetch_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                exp_stb: 1'b0};
            s_d.clk_en      = 1'b0;
        end else begin
            case (s_q.phase)
                `EBI_LAST_STATE: begin
                    // Stop when step is low after one honoured cycle
                    if (!step_s && s_q.step_seen) begin
                        s_d.phase = `EBI_LAST_STATE;
                        s_d.op    = EBI_OP_NONE;
                    end else begin
                        s_d.op       = req_in.op;
                        s_d.addr     = req_in.addr;
                        s_d.wdata    = req_in.wdata;
                        s_d.port     = req_in.port;
                        s_d.step_seen = !step_s;
                        if (req_in.op == EBI_OP_FETCH && !ext_f) begin
                            s_d.op = EBI_OP_NONE;
                        end
                        // Latch strobe high once per cycle
                        s_d.pins.ale = 1'b1;
                        s_d.pins.bus_o = (req_in.op == EBI_OP_FETCH) ?
                                         req_in.addr[7:0] : req_in.wdata;
                        s_d.pins.bus_oe = (req_in.op == EBI_OP_FETCH && ext_f) ||
                                          req_in.op == EBI_OP_DREAD ||
                                          req_in.op == EBI_OP_DWRITE;
                        if (req_in.op == EBI_OP_DREAD || req_in.op == EBI_OP_DWRITE) begin
                            s_d.pins.bus_o = req_in.addr[7:0];
                        end
                        s_d.pins.p2_o  = req_in.addr[11:8];
                        s_d.pins.p2_oe = (req_in.op == EBI_OP_FETCH && ext_f);
                        if (req_in.op == EBI_OP_EXP_RD || req_in.op == EBI_OP_EXP_WR) begin
                            s_d.nib = 2'h0;
                        end
                    end
                end
                `EBI_ALE_STATE: begin
                    // Address still held while latch strobe falls
                    s_d.pins.ale = 1'b0;
                    if (s_q.op == EBI_OP_FETCH) begin
                        s_d.pins.fetch_n = 1'b0;
                    end
                    if (s_q.op == EBI_OP_EXP_RD || s_q.op == EBI_OP_EXP_WR) begin
                        // First nibble: opcode and port 4..7
                        s_d.pins.p2_o  = {(s_q.op == EBI_OP_EXP_WR) ?
                                          `EBI_EXP_OP_WRITE : `EBI_EXP_OP_READ,
                                          s_q.port};
                        s_d.pins.p2_oe = 1'b1;
                        s_d.pins.exp_stb = 1'b1;
                    end
                end
                `EBI_ADDR_STATE: begin
                    // Bus turnaround after latch edge has passed
                    if (s_q.op == EBI_OP_FETCH || s_q.op == EBI_OP_DREAD) begin
                        s_d.pins.bus_oe = 1'b0;
                    end
                    if (s_q.op == EBI_OP_DWRITE) begin
                        s_d.pins.bus_o = s_q.wdata;
                        s_d.pins.wr_n  = 1'b0;
                    end
                    if (s_q.op == EBI_OP_DREAD) begin
                        s_d.pins.rd_n = 1'b0;
                    end
                    if (s_q.op == EBI_OP_EXP_RD || s_q.op == EBI_OP_EXP_WR) begin
                        // Falling strobe ends opcode nibble; second is data
                        s_d.pins.exp_stb = 1'b0;
                        s_d.pins.p2_o  = s_q.wdata[3:0];
                        s_d.pins.p2_oe = (s_q.op == EBI_OP_EXP_WR);
                    end
                end
                `EBI_STROBE_STATE: begin
                    if (s_q.op == EBI_OP_EXP_RD || s_q.op == EBI_OP_EXP_WR) begin
                        s_d.pins.exp_stb = 1'b0;
                    end
                end
                `EBI_SAMPLE_STATE: begin
                    // Data sampled at trailing edge of the read strobes
                    if (s_q.op == EBI_OP_FETCH || s_q.op == EBI_OP_DREAD) begin
                        s_d.rdata  = bus_in;
                        s_d.rvalid = 1'b1;
                    end
                    if (s_q.op == EBI_OP_EXP_RD) begin
                        s_d.rdata  = {4'h0, p2_in};
                        s_d.rvalid = 1'b1;
                    end
                    // Store data released on the same edge as the strobe rise
                    s_d.pins.fetch_n = 1'b1;
                    s_d.pins.rd_n    = 1'b1;
                    s_d.pins.wr_n    = 1'b1;
                    s_d.pins.exp_stb = 1'b0;
                end
                default: begin
                    s_d.phase = `EBI_ALE_STATE;
                end
            endcase
            // Release nibble lines on the same edge as the strobes rise
            if (s_q.phase == `EBI_SAMPLE_STATE) begin
                s_d.pins.p2_oe = 1'b0;
            end
            if (s_q.phase == `EBI_SAMPLE_STATE && s_q.op == EBI_OP_DWRITE) begin
                s_d.pins.bus_oe = 1'b1;
            end
            if (s_q.phase == `EBI_LAST_STATE - 3'h0 && s_q.op != EBI_OP_NONE &&
                s_q.pins.wr_n && s_q.pins.rd_n && s_q.pins.fetch_n) begin
                s_d.pins.bus_oe = s_d.pins.bus_oe;
            end
        end
        // Float the bus at the end of the sample state, store cycles included
        if (!s_q.ro_mode && s_q.phase == `EBI_SAMPLE_STATE) begin
            s_d.pins.bus_oe = 1'b0;
        end
    end

    // ======================================================================
    // State register
    // ======================================================================
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_q <= '{phase: `EBI_LAST_STATE, op: EBI_OP_NONE, addr: `EBI_RESET_PC,
                     wdata: 8'h00, port: 2'h0, nib: 2'h0, rdata: 8'h00,
                     rvalid: 1'b0, clk_en: 1'b0, run_mode: 1'b0, ro_mode: 1'b0,
                     rst_pin: 1'b0, step_seen: 1'b0, ro_addr: 11'h000,
                     pins: '{bus_o: 8'h00, bus_oe: 1'b0, p2_o: 4'h0, p2_oe: 1'b0,
                             ale: 1'b0, fetch_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                             exp_stb: 1'b0}};
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign req_ready_out   = start && rst_s && !s_q.ro_mode &&
                             !(!step_s && s_q.step_seen);
    assign rdata_valid_out = s_q.rvalid;
    assign rdata_out       = s_q.rdata;
    assign ext_fetch_out   = ext_f;
    assign stopped_out     = start && !step_s && s_q.step_seen;
    // Fetch strobe only in fetch cycles, data strobes only in data cycles
    assign fetch_n_out     = s_q.pins.fetch_n;
    assign rd_n_out        = s_q.pins.rd_n;
    assign wr_n_out        = s_q.pins.wr_n;
    assign bus_out         = s_q.pins.bus_o;
    assign bus_oe_out      = s_q.pins.bus_oe;
    assign p2_out          = s_q.pins.p2_o;
    assign p2_oe_out       = s_q.pins.p2_oe;
    assign ale_out         = s_q.pins.ale;
    assign exp_stb_out     = s_q.pins.exp_stb;
    // Gated clock out; glitch hazard accepted, enable can change in any state
    assign clk_pin_out     = s_q.clk_en & phase2_in;
    assign rom_addr_out    = s_q.ro_mode ? s_q.ro_addr : s_q.addr[10:0];
    // RAM blocked while reset pin is low
    assign ram_we_out      = ram_we_in & rst_s;
    assign ram_re_out      = ram_re_in & rst_s;
endmodule

// *** tb/ebi_checker.sv ***
// Port-level assertions for ebi_core.
// Assumes the bind at the foot of this file; one clock domain.
`timescale 1ns/1ps
module ebi_checker (
    input wire logic       clk_in, reset_in, phase2_in, reset_pin_in, clk_pin_out,
    input wire logic       ale_out, fetch_n_out, rd_n_out, wr_n_out, bus_oe_out,
    input wire logic       exp_stb_out, p2_oe_out, rdata_valid_out, ram_we_out, ram_re_out,
    input wire logic [7:0] bus_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    ale_per_cycle_a: assert property (ale_out |=> !ale_out [*4])
        else $error("latch strobe closer than five states");
    strobe_excl_a: assert property (!(!rd_n_out && !wr_n_out))
        else $error("read and store strobes together");
    fetch_alone_a: assert property (!fetch_n_out |-> rd_n_out && wr_n_out)
        else $error("fetch strobe beside a data strobe");
    addr_hold_a: assert property ($fell(ale_out) |-> $stable(bus_oe_out) && $stable(bus_out))
        else $error("address moved at latch fall");
    fetch_after_ale_a: assert property ($fell(fetch_n_out) |-> $past(ale_out))
        else $error("fetch strobe without latch pulse");
    fetch_data_a: assert property ($fell(fetch_n_out) |-> ##[1:3] rdata_valid_out)
        else $error("fetched byte not delivered");
    read_turn_a: assert property (!rd_n_out |-> !bus_oe_out)
        else $error("bus driven during read");
    store_drive_a: assert property (!wr_n_out |-> bus_oe_out)
        else $error("store data not driven");
    nibble_drive_a: assert property (exp_stb_out |-> p2_oe_out)
        else $error("expander nibble not driven");
    ram_guard_a: assert property (!reset_pin_in [*5] |-> !ram_we_out && !ram_re_out)
        else $error("ram reachable in standby");
    clk_gate_a: assert property (clk_pin_out |-> phase2_in)
        else $error("clock pin not from phase two");
endmodule

bind ebi_core ebi_checker u_chk (.clk_in(clk_in), .reset_in(reset_in), .phase2_in(phase2_in),
    .reset_pin_in(reset_pin_in), .clk_pin_out(clk_pin_out), .ale_out(ale_out),
    .fetch_n_out(fetch_n_out), .rd_n_out(rd_n_out), .wr_n_out(wr_n_out),
    .bus_oe_out(bus_oe_out), .exp_stb_out(exp_stb_out), .p2_oe_out(p2_oe_out),
    .rdata_valid_out(rdata_valid_out), .ram_we_out(ram_we_out), .ram_re_out(ram_re_out),
    .bus_out(bus_out));

// *** tb/ebi_ext_mem.sv ***
// Far side: program and data memory, address latch, nibble expander.
// Assumes registered device pins, so all sampling is on the falling edge.
`timescale 1ns/1ps
module ebi_ext_mem (
    input  wire logic       clk_in,
    input  wire logic       ale_in, fetch_n_in, rd_n_in, wr_n_in, stb_in, p2_oe_in,
    input  wire logic [7:0] bus_in,
    input  wire logic [3:0] p2_in,
    output logic      [7:0] bus_out,
    output logic      [3:0] p2_out
);
    logic [11:0] addr_q;        // Latched address
    logic [7:0]  dmem_q [256];  // Data memory
    logic [3:0]  port_q [4];    // Expander ports four to seven
    logic [3:0]  nib1_q;        // Opcode and port nibble
    logic        ale_q, stb_q, got_q;
    logic [7:0]  last_q;
    // Released bus shows the inverse of its last value, never a stale copy
    assign bus_out = !fetch_n_in ? (addr_q[7:0] ^ {addr_q[11:8], 4'h5})
                   : (!rd_n_in ? dmem_q[addr_q[7:0]] : ~last_q);
    assign p2_out  = (got_q && !stb_in && !nib1_q[2]) ? port_q[nib1_q[1:0]] : ~nib1_q;
    always @(negedge clk_in) begin
        ale_q  <= ale_in;
        stb_q  <= stb_in;
        last_q <= bus_out;
        if (ale_q && !ale_in) addr_q <= {p2_in, bus_in};
        if (!wr_n_in) dmem_q[addr_q[7:0]] <= bus_in;
        if (ale_in) got_q <= 1'b0;
        if (stb_in && !stb_q) begin
            nib1_q <= p2_in;
            got_q  <= 1'b1;
        end
        if (got_q && !stb_in && p2_oe_in && nib1_q[2]) port_q[nib1_q[1:0]] <= p2_in;
    end
endmodule

// *** tb/external_bus_interface_bench.sv ***
// Self-checking bench for ebi_core beside the far-side memory model.
// Assumes ebi_checker is bound by its own file.
`timescale 1ns/1ps
module external_bus_interface_bench;
    import ebi_pkg::*;
    logic clk_in = 0, reset_in = 1, clk_out_en_in = 0, phase2_in = 0, ro_on = 0;
    logic ram_we_in = 0, ram_re_in = 0, ext_sel_hi_in = 0, reset_pin_in = 1, step_in = 1;
    logic [1:0]  expander_strobe_mode_in = 2'h2;
    logic [10:0] ro_a = '0, rom_addr_out;
    ebi_req_t    req_in = '0;
    logic req_ready_out, rdata_valid_out, ext_fetch_out, stopped_out, ram_we_out, ram_re_out;
    logic bus_oe_out, p2_oe_out, ale_out, fetch_n_out, rd_n_out, wr_n_out, exp_stb_out;
    logic clk_pin_out;
    logic [7:0]  rdata_out, bus_out, bus_in, mem_bus;
    logic [3:0]  p2_out, p2_in, mem_p2;
    int          miscompares = 0, samples_checked = 0;
    // Wire level: device first, then read-out address, then far side
    assign bus_in = bus_oe_out ? bus_out : (ro_on ? ro_a[7:0] : mem_bus);
    assign p2_in  = p2_oe_out ? p2_out : (ro_on ? {1'b0, ro_a[10:8]} : mem_p2);
    initial forever #50 clk_in = ~clk_in;
    always @(posedge clk_in) phase2_in <= ~phase2_in;
    ebi_core u_dut (.clk_in(clk_in), .reset_in(reset_in), .req_in(req_in),
        .expander_strobe_mode_in(expander_strobe_mode_in), .clk_out_en_in(clk_out_en_in), .phase2_in(phase2_in),
        .req_ready_out(req_ready_out), .rdata_valid_out(rdata_valid_out),
        .rdata_out(rdata_out), .ext_fetch_out(ext_fetch_out), .stopped_out(stopped_out),
        .ram_we_in(ram_we_in), .ram_re_in(ram_re_in), .ram_we_out(ram_we_out),
        .ram_re_out(ram_re_out), .bus_in(bus_in), .bus_out(bus_out), .bus_oe_out(bus_oe_out),
        .p2_in(p2_in), .p2_out(p2_out), .p2_oe_out(p2_oe_out), .ale_out(ale_out),
        .fetch_n_out(fetch_n_out), .rd_n_out(rd_n_out), .wr_n_out(wr_n_out),
        .exp_stb_out(exp_stb_out), .clk_pin_out(clk_pin_out), .ext_sel_hi_in(ext_sel_hi_in),
        .reset_pin_in(reset_pin_in), .step_in(step_in),
        .rom_data_in(rom_addr_out[7:0] ^ 8'h3c), .rom_addr_out(rom_addr_out));
    ebi_ext_mem u_mem (.clk_in(clk_in), .ale_in(ale_out), .fetch_n_in(fetch_n_out),
        .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .stb_in(exp_stb_out), .p2_oe_in(p2_oe_out),
        .bus_in(bus_out), .p2_in(p2_out), .bus_out(mem_bus), .p2_out(mem_p2));
    function automatic logic [7:0] rom_exp(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h5};
    endfunction
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask
    task automatic complete_run();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hold the request up to its taking edge, then optionally await the byte
    task automatic go(input ebi_op_t op, input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] p, input logic wt, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk_in);
        req_in <= '{op: op, addr: a, wdata: d, port: p};
        do @(negedge clk_in); while (req_ready_out !== 1'b1 && ++n < 40);
        chk(req_ready_out === 1'b1, "request not taken");
        @(posedge clk_in);
        n = 0;
        if (wt) do @(negedge clk_in); while (rdata_valid_out !== 1'b1 && ++n < 12);
        if (wt) chk(rdata_valid_out === 1'b1, "no read data");
        rd = rdata_out;
    endtask
    initial begin
        logic [7:0]  rd, d;
        logic [11:0] a;
        logic [1:0]  md [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
        logic [11:0] ad [4] = '{12'h0100, 12'h07FF, 12'h0800, 12'h0000};
        int          r;
        r = $urandom(98);
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (8) @(negedge clk_in);
        chk(bus_oe_out === 1'b0 && fetch_n_out === 1'b1, "bus not idle");
        for (int i = 0; i < 10; i++) begin
            a = (i < 4) ? ad[i] : 12'($urandom);
            expander_strobe_mode_in <= (i < 4) ? md[i] : 2'h2;
            req_in <= '{op: EBI_OP_FETCH, addr: a, wdata: 8'h00, port: 2'h0};
            repeat (2) @(negedge clk_in);
            r = (expander_strobe_mode_in == 2'h2 || (expander_strobe_mode_in == 2'h1 && a > 12'h07FF)) ? 1 : 0;
            chk(ext_fetch_out === r[0], "fetch source");
            go(EBI_OP_FETCH, a, 8'h00, 2'h0, r[0], rd);
            if (r[0]) chk(rd === rom_exp(a), "fetched byte");
        end
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 12'h0FF : 12'($urandom % 256);
            d = 8'($urandom);
            go(EBI_OP_DWRITE, a, d, 2'h0, 1'b0, rd);
            go(EBI_OP_DREAD, a, 8'h00, 2'h0, 1'b1, rd);
            chk(rd === d, "data readback");
        end
        for (int p = 0; p < 4; p++) begin
            d = 8'($urandom % 16);
            go(EBI_OP_EXP_WR, 12'h000, d, 2'(p), 1'b0, rd);
            go(EBI_OP_EXP_RD, 12'h000, 8'h00, 2'(p), 1'b1, rd);
            chk(u_mem.nib1_q === {2'h0, 2'(p)} && rd === d, "expander");
        end
        repeat (2) @(negedge clk_in) chk(clk_pin_out === 1'b0, "clock leaked");
        clk_out_en_in <= 1'b1;
        repeat (2) @(negedge clk_in) chk(clk_pin_out === phase2_in, "no clock");
        ram_we_in <= 1'b1;
        ram_re_in <= 1'b1;
        @(negedge clk_in) chk(ram_we_out === 1'b1 && ram_re_out === 1'b1, "ram shut");
        reset_pin_in <= 1'b0;
        ext_sel_hi_in <= 1'b1;
        ro_on <= 1'b1;
        ro_a <= 10'($urandom);
        repeat (6) @(negedge clk_in);
        chk(ram_we_out === 1'b0 && ram_re_out === 1'b0, "ram open");
        reset_pin_in <= 1'b1;
        repeat (8) @(negedge clk_in);
        chk(rom_addr_out === ro_a && bus_out === (ro_a[7:0] ^ 8'h3c), "readout");
        ext_sel_hi_in <= 1'b0;
        step_in <= 1'b0;
        repeat (20) @(negedge clk_in);
        chk(stopped_out === 1'b1, "not stopped");
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        complete_run();
    end
endmodule
